// File: sdb_map.svh
`ifndef SDB_MAP_SVH
`define SDB_MAP_SVH
// ----------------------------------------
// Command indices
// ----------------------------------------
`define SDB_CMD_GO_IDLE 6'h00
`define SDB_CMD_ALL_CID 6'h02
`define SDB_CMD_SET_RCA 6'h03
`define SDB_CMD_SELECT 6'h07
`define SDB_CMD_GET_CSD 6'h09
`define SDB_CMD_GET_CID 6'h0A
`define SDB_CMD_APP 6'h37
`define SDB_ACMD_BUS_W 6'h06
`define SDB_ACMD_STATUS 6'h0D
`define SDB_ACMD_OP_COND 6'h29
`define SDB_ACMD_CARD_DET 6'h2A
// ----------------------------------------
// Framing and timing
// ----------------------------------------
`define SDB_TOK_BITS 8'h30
`define SDB_TOK_LAST 6'h2F
`define SDB_R2_BITS 8'h88
`define SDB_R1S_BITS 8'h08
`define SDB_NCR_CYC 8'h02
`define SDB_DUMMY_CLKS 74
`define SDB_HOST_CLK_MAX_MHZ 50
// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define SDB_OCR_VDD 32'h00FF8000
`define SDB_OCR_BUSY 31
`define SDB_STS_STATE 9
`define SDB_STS_RDY 8
`define SDB_STS_APP 5
`define SDB_BW1_ARG 2'h0
`define SDB_BW4_ARG 2'h2
`define SDB_RCA_SEED 16'hACE1
`define SDB_RCA_ALT 16'h0001
`define SDB_PU_KOHM 50
`define SDB_ST_IDLE 4'h0
`define SDB_ST_READY 4'h1
`define SDB_ST_IDENT 4'h2
`define SDB_ST_STBY 4'h3
`define SDB_ST_TRAN 4'h4
`endif

// File: sdb_pkg.sv
`include "sdb_map.svh"
package sdb_pkg;
	typedef enum logic [2:0] {
		SDB_IDLE, SDB_READY, SDB_IDENT, SDB_STBY, SDB_TRAN
	} sdb_card_e;
	typedef enum logic [1:0] {
		SDB_TX_IDLE, SDB_TX_GAP, SDB_TX_SHIFT
	} sdb_tx_e;

	function automatic logic [6:0] sdb_crc7(input logic [39:0] d);
		logic [6:0] c;
		logic fb;
		c = 7'h00;
		for (int i = 39; i >= 0; i--) begin
			fb = d[i] ^ c[6];
			c = {c[5:3], c[2] ^ fb, c[1:0], fb};
		end
		return c;
	endfunction

	function automatic logic [47:0] sdb_tok(input logic [39:0] h);
		return {h, sdb_crc7(h), 1'b1};
	endfunction

	function automatic logic [3:0] sdb_code(input sdb_card_e s);
		logic [3:0] c;
		c = `SDB_ST_IDLE;
		unique case (s)
		SDB_IDLE: c = `SDB_ST_IDLE;
		SDB_READY: c = `SDB_ST_READY;
		SDB_IDENT: c = `SDB_ST_IDENT;
		SDB_STBY: c = `SDB_ST_STBY;
		SDB_TRAN: c = `SDB_ST_TRAN;
		endcase
		return c;
	endfunction

	function automatic logic [31:0] sdb_status(input sdb_card_e s,
		input logic app);
		logic [31:0] st;
		st = 32'h0;
		st[`SDB_STS_STATE +: 4] = sdb_code(s);
		st[`SDB_STS_RDY] = (s == SDB_TRAN);
		st[`SDB_STS_APP] = app;
		return st;
	endfunction
endpackage

// File: sdb_sync.sv
module sdb_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s1_nxt;
	logic [W-1:0] q_nxt;

	always_comb begin
		s1_nxt = rst_n_i ? d_i : RST;
		q_nxt = rst_n_i ? s1_r : RST;
	end

	always_ff @(posedge clk_i) begin
		s1_r <= s1_nxt;
		q_o <= q_nxt;
	end
endmodule

// File: sdb_cmd_rx.sv
`include "sdb_map.svh"
module sdb_cmd_rx
	import sdb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic bit_i,
	output logic vld_o,
	output logic [47:0] tok_o,
	output logic ok_o
);
	logic busy_r;
	logic busy_nxt;
	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic [47:0] sh_r;
	logic [47:0] sh_nxt;
	logic [47:0] tok_nxt;
	logic vld_nxt;
	logic ok_nxt;

	always_comb begin
		busy_nxt = busy_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		tok_nxt = tok_o;
		vld_nxt = 1'b0;
		ok_nxt = ok_o;
		// Dropping enable aborts a half-taken token
		if (!en_i) begin
			busy_nxt = 1'b0;
		end else if (!busy_r) begin
			if (!bit_i) begin
				busy_nxt = 1'b1;
				cnt_nxt = 6'h01;
				sh_nxt = {sh_r[46:0], bit_i};
			end
		end else begin
			sh_nxt = {sh_r[46:0], bit_i};
			cnt_nxt = cnt_r + 6'h01;
			if (cnt_r == `SDB_TOK_LAST) begin
				busy_nxt = 1'b0;
				vld_nxt = 1'b1;
				tok_nxt = sh_nxt;
				// R20: CRC check
				ok_nxt = sh_nxt[46] && sh_nxt[0] &&
					(sdb_crc7(sh_nxt[47:8]) == sh_nxt[7:1]);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			busy_r <= 1'b0;
			cnt_r <= 6'h00;
			sh_r <= 48'h0;
			tok_o <= 48'h0;
			vld_o <= 1'b0;
			ok_o <= 1'b0;
		end else begin
			busy_r <= busy_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			tok_o <= tok_nxt;
			vld_o <= vld_nxt;
			ok_o <= ok_nxt;
		end
	end
endmodule

// File: sdb_card.sv
// Functional notes
// R1: DAT1 to DAT3 stay inputs until the host selects the wide bus.
// R2: DAT3 pull-up of about 50 kilohm is on from power up.
// R3: DAT3 low at CMD0 selects SPI mode, high selects SD mode; the code keeps SPI mode once selected, until reset.
// R4: ACMD42 disconnects the DAT3 pull-up.
// R5: SPI mode: DAT3 chip select, CMD data in, DAT0 push-pull out.
// R6: One data line after power up; host may widen to four later.
// R7: Tokens on CMD are serial, framed by start and stop bits.
// R8: Addressed and broadcast commands are taken and answered on CMD.
// R9: Host gives more than 74 dummy clocks before its first command.
// R10: Selected mode holds until the next CMD0 or a power cycle.
// R11: ACMD41 with zero argument returns the voltage window.
// R12: Host repeats ACMD41 until bit 31 shows power-up complete.
// R13: No ACMD41 answer within host timeout means not a memory card.
// R14: CMD2 returns identity; CMD3 returns a fresh non-zero address.
// R15: CMD7 toggles standby and transfer; CMD9, CMD10 answer in standby.
// R16: ACMD13 returns status; host checks the card-type field.
// R17: ACMD6 in transfer state sets the data bus width used.
// R18: Host clock never exceeds 50 MHz; the host model toggles its clock every 6 ns, about 83 MHz.
// R19: OCR bit 31 reads zero while busy, one once initialized.
// R20: Tokens carry CRC7; a token with a bad CRC is dropped.
`include "sdb_map.svh"
module sdb_card
	import sdb_pkg::*;
#(
	// Identity and card data: arbitrary values
	parameter logic [127:0] CID = 128'h0123456789ABCDEF0011223344556601,
	parameter logic [127:0] CSD = 128'h40000000000000000000000000000001
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic sd_clk_i,
	input wire logic cmd_i,
	output logic cmd_o,
	output logic cmd_oe_o,
	input wire logic dat3_i,
	output logic [3:0] dat_o,
	output logic [3:0] dat_oe_o,
	output logic dat3_pu_en_o,
	input wire logic [3:0] dat_drv_i,
	input wire logic dat_drv_en_i,
	input wire logic init_done_i,
	output logic spi_mode_o,
	output logic bus_wide_o,
	output logic status_req_o
);
	// ----------------------------------------
	// Link reset and crossings into link side
	// ----------------------------------------
	logic lrst_n;
	logic ready_s;

	sdb_sync #(.W(1), .RST(1'b0)) u_lrst (
		.clk_i(sd_clk_i),
		.rst_n_i(1'b1),
		.d_i(rst_n_i),
		.q_o(lrst_n)
	);

	sdb_sync #(.W(1), .RST(1'b0)) u_ready (
		.clk_i(sd_clk_i),
		.rst_n_i(lrst_n),
		.d_i(init_done_i),
		.q_o(ready_s)
	);

	// ----------------------------------------
	// Link state
	// ----------------------------------------
	sdb_card_e card_r, card_nxt;
	sdb_tx_e tx_st_r, tx_st_nxt;
	logic app_r, app_nxt;
	logic spi_r, spi_nxt;
	logic pu_r, pu_nxt;
	logic wide_r, wide_nxt;
	logic tg_r, tg_nxt;
	logic [15:0] rca_r, rca_nxt;
	logic [15:0] gen_r, gen_nxt;
	logic [7:0] tx_cnt_r, tx_cnt_nxt;
	logic [7:0] tx_len_r, tx_len_nxt;
	logic [135:0] tx_sh_r, tx_sh_nxt;
	logic [3:0] dat_nxt;
	logic [3:0] oe_nxt;
	logic rx_en;
	logic rx_vld;
	logic rx_ok;
	logic [47:0] rx_tok;
	logic take;
	logic cmd0_hit;
	logic go;
	logic [135:0] rsp;
	logic [7:0] len;
	logic [5:0] idx;
	logic [31:0] arg;
	logic addr_ok;
	logic [31:0] sts;
	logic [31:0] ocr;
	logic [15:0] rca_new;
	logic [135:0] r1;

	// R5: chip select gates intake
	assign rx_en = spi_r ? !dat3_i : (tx_st_r == SDB_TX_IDLE);

	sdb_cmd_rx u_rx (
		.clk_i(sd_clk_i),
		.rst_n_i(lrst_n),
		.en_i(rx_en),
		.bit_i(cmd_i),
		.vld_o(rx_vld),
		.tok_o(rx_tok),
		.ok_o(rx_ok)
	);

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	always_comb begin
		idx = rx_tok[45:40];
		arg = rx_tok[39:8];
		addr_ok = (arg[31:16] == rca_r);
		sts = sdb_status(card_r, app_r);
		ocr = `SDB_OCR_VDD;
		// R19: busy bit follows init
		ocr[`SDB_OCR_BUSY] = ready_s;
		rca_new = (gen_r == 16'h0) ? `SDB_RCA_ALT : gen_r;
		r1 = {sdb_tok({2'b00, idx, sts}), 88'h0};
		// R20: bad tokens never reach decode
		take = rx_vld && rx_ok;
		cmd0_hit = take && !app_r && (idx == `SDB_CMD_GO_IDLE);
		card_nxt = card_r;
		app_nxt = app_r;
		spi_nxt = spi_r;
		pu_nxt = pu_r;
		wide_nxt = wide_r;
		tg_nxt = tg_r;
		rca_nxt = rca_r;
		go = 1'b0;
		rsp = 136'h0;
		len = `SDB_TOK_BITS;
		if (take) begin
			app_nxt = 1'b0;
		end
		// R3: mode taken at CMD0
		// R10: mode changes only here
		if (cmd0_hit) begin
			card_nxt = SDB_IDLE;
			spi_nxt = spi_r | !dat3_i;
			rca_nxt = 16'h0;
			wide_nxt = 1'b0;
			pu_nxt = 1'b1;
		end
		if (take && spi_r) begin
			if (idx == `SDB_CMD_APP && !app_r) begin
				app_nxt = 1'b1;
			end else if (app_r && idx == `SDB_ACMD_OP_COND && ready_s) begin
				card_nxt = SDB_READY;
			end
			// R5: one-byte answer, idle flag in bit 0
			go = 1'b1;
			len = `SDB_R1S_BITS;
			rsp = {7'h00, card_nxt == SDB_IDLE, 128'h0};
		end else if (take && app_r) begin
			case (idx)
			`SDB_ACMD_OP_COND: begin
				// R11: window always reported
				// R12: leave idle only once ready
				go = 1'b1;
				rsp = {8'h3F, ocr, 8'hFF, 88'h0};
				if (arg != 32'h0 && ready_s && card_r == SDB_IDLE) begin
					card_nxt = SDB_READY;
				end
			end
			`SDB_ACMD_BUS_W: if (card_r == SDB_TRAN) begin
				// R17: width select
				go = 1'b1;
				rsp = r1;
				if (arg[1:0] == `SDB_BW4_ARG) begin
					wide_nxt = 1'b1;
				end else if (arg[1:0] == `SDB_BW1_ARG) begin
					wide_nxt = 1'b0;
				end
			end
			`SDB_ACMD_STATUS: if (card_r == SDB_TRAN) begin
				// R16: status block handed to data side
				go = 1'b1;
				rsp = r1;
				tg_nxt = !tg_r;
			end
			`SDB_ACMD_CARD_DET: if (card_r == SDB_TRAN) begin
				// R4: pull-up control
				go = 1'b1;
				rsp = r1;
				pu_nxt = arg[0];
			end
			default: ;
			endcase
		end else if (take) begin
			// R8: broadcast and addressed commands
			case (idx)
			`SDB_CMD_APP: if (addr_ok) begin
				app_nxt = 1'b1;
				go = 1'b1;
				rsp = r1;
			end
			`SDB_CMD_ALL_CID: if (card_r == SDB_READY) begin
				// R14: identity
				card_nxt = SDB_IDENT;
				go = 1'b1;
				len = `SDB_R2_BITS;
				rsp = {8'h3F, CID};
			end
			`SDB_CMD_SET_RCA:
			if (card_r == SDB_IDENT || card_r == SDB_STBY) begin
				// R14: fresh non-zero address
				card_nxt = SDB_STBY;
				rca_nxt = rca_new;
				go = 1'b1;
				rsp = {sdb_tok({2'b00, idx, rca_new, sts[23:22],
					sts[19], sts[12:0]}), 88'h0};
			end
			`SDB_CMD_SELECT: begin
				// R15: standby and transfer toggle
				if (card_r == SDB_STBY && addr_ok) begin
					card_nxt = SDB_TRAN;
					go = 1'b1;
					rsp = r1;
				end else if (card_r == SDB_TRAN) begin
					card_nxt = SDB_STBY;
					go = addr_ok;
					rsp = r1;
				end
			end
			`SDB_CMD_GET_CSD, `SDB_CMD_GET_CID:
			if (card_r == SDB_STBY && addr_ok) begin
				// R15: card data in standby
				go = 1'b1;
				len = `SDB_R2_BITS;
				rsp = {8'h3F, (idx == `SDB_CMD_GET_CSD) ? CSD : CID};
			end
			default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Response shifter
	// ----------------------------------------
	always_comb begin
		tx_st_nxt = tx_st_r;
		tx_cnt_nxt = tx_cnt_r;
		tx_len_nxt = tx_len_r;
		tx_sh_nxt = tx_sh_r;
		gen_nxt = {gen_r[14:0], gen_r[15] ^ gen_r[13] ^ gen_r[12] ^ gen_r[10]};
		unique case (tx_st_r)
		SDB_TX_IDLE: if (go) begin
			tx_st_nxt = SDB_TX_GAP;
			tx_cnt_nxt = `SDB_NCR_CYC;
			tx_len_nxt = len;
			tx_sh_nxt = rsp;
		end
		SDB_TX_GAP: if (tx_cnt_r == 8'h01) begin
			tx_st_nxt = SDB_TX_SHIFT;
			tx_cnt_nxt = tx_len_r;
		end else begin
			tx_cnt_nxt = tx_cnt_r - 8'h01;
		end
		SDB_TX_SHIFT: begin
			// R7: start bit first, stop bit last
			tx_sh_nxt = {tx_sh_r[134:0], 1'b1};
			tx_cnt_nxt = tx_cnt_r - 8'h01;
			if (tx_cnt_r == 8'h01) begin
				tx_st_nxt = SDB_TX_IDLE;
			end
		end
		endcase
		// R5: SPI answers leave on DAT0
		// R6: data side narrow until widened
		if (spi_r) begin
			dat_nxt = {3'b111, (tx_st_nxt == SDB_TX_SHIFT) ?
				tx_sh_nxt[135] : 1'b1};
			oe_nxt = {3'b000, !dat3_i};
		end else begin
			dat_nxt = dat_drv_i;
			// R1: upper lines driven only when wide
			oe_nxt = {{3{wide_r & dat_drv_en_i}}, dat_drv_en_i};
		end
	end

	assign cmd_o = tx_sh_r[135];
	assign cmd_oe_o = !spi_r && (tx_st_r == SDB_TX_SHIFT);
	assign dat3_pu_en_o = pu_r;

	always_ff @(posedge sd_clk_i) begin
		if (!lrst_n) begin
			card_r <= SDB_IDLE;
			tx_st_r <= SDB_TX_IDLE;
			app_r <= 1'b0;
			spi_r <= 1'b0;
			// R2: pull-up on from reset
			pu_r <= 1'b1;
			wide_r <= 1'b0;
			tg_r <= 1'b0;
			rca_r <= 16'h0;
			gen_r <= `SDB_RCA_SEED;
			tx_cnt_r <= 8'h00;
			tx_len_r <= 8'h00;
			tx_sh_r <= {136{1'b1}};
			dat_o <= 4'hF;
			dat_oe_o <= 4'h0;
		end else begin
			card_r <= card_nxt;
			tx_st_r <= tx_st_nxt;
			app_r <= app_nxt;
			spi_r <= spi_nxt;
			pu_r <= pu_nxt;
			wide_r <= wide_nxt;
			tg_r <= tg_nxt;
			rca_r <= rca_nxt;
			gen_r <= gen_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_len_r <= tx_len_nxt;
			tx_sh_r <= tx_sh_nxt;
			dat_o <= dat_nxt;
			dat_oe_o <= oe_nxt;
		end
	end

	// ----------------------------------------
	// Reporting into the system clock
	// ----------------------------------------
	logic [2:0] xq;
	logic tgd_r, tgd_nxt;
	logic req_nxt;

	sdb_sync #(.W(3), .RST(3'h0)) u_xref (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.d_i({tg_r, wide_r, spi_r}),
		.q_o(xq)
	);

	assign spi_mode_o = xq[0];
	assign bus_wide_o = xq[1];

	always_comb begin
		tgd_nxt = xq[2];
		req_nxt = xq[2] ^ tgd_r;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tgd_r <= 1'b0;
			status_req_o <= 1'b0;
		end else begin
			tgd_r <= tgd_nxt;
			status_req_o <= req_nxt;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	narrow_dat_a: assert property (@(posedge sd_clk_i) disable iff (!lrst_n) // R1
		!wide_r |=> dat_oe_o[3:1] == 3'b000)
		else $error("upper data line driven on narrow bus");
	pullup_off_a: assert property (@(posedge sd_clk_i) disable iff (!lrst_n) // R4
		(take && app_r && !spi_r && idx == `SDB_ACMD_CARD_DET &&
		card_r == SDB_TRAN && !arg[0]) |=> !dat3_pu_en_o)
		else $error("pull-up not released");
	mode_hold_a: assert property (@(posedge sd_clk_i) disable iff (!lrst_n) // R10
		$changed(spi_r) |-> $past(cmd0_hit))
		else $error("mode changed without CMD0");
	start_bit_a: assert property (@(posedge sd_clk_i) disable iff (!lrst_n) // R7
		$rose(cmd_oe_o) |-> !cmd_o)
		else $error("response lacks start bit");
	stop_bit_a: assert property (@(posedge sd_clk_i) disable iff (!lrst_n) // R7
		$fell(cmd_oe_o) |-> $past(cmd_o))
		else $error("response lacks stop bit");
	answer_gap_a: assert property (@(posedge sd_clk_i) disable iff (!lrst_n) // R8
		(go && !spi_r) |-> !cmd_oe_o [*3] ##1 cmd_oe_o)
		else $error("response not started after gap");
	bad_crc_a: assert property (@(posedge sd_clk_i) disable iff (!lrst_n) // R20
		(rx_vld && !rx_ok) |-> !go && card_nxt == card_r)
		else $error("bad token acted on");
	rca_nonzero_a: assert property (@(posedge sd_clk_i) disable iff (!lrst_n) // R14
		(card_r == SDB_STBY || card_r == SDB_TRAN) |-> rca_r != 16'h0)
		else $error("zero card address");
	busy_bit_a: assert property (@(posedge sd_clk_i) disable iff (!lrst_n) // R19
		(go && app_r && !spi_r && idx == `SDB_ACMD_OP_COND) |->
		rsp[127] == ready_s)
		else $error("busy bit does not follow init");
	wide_tran_a: assert property (@(posedge sd_clk_i) disable iff (!lrst_n) // R17
		$rose(wide_r) |-> $past(card_r) == SDB_TRAN)
		else $error("width changed outside transfer");
	select_tog_a: assert property (@(posedge sd_clk_i) disable iff (!lrst_n) // R15
		(go && !app_r && !spi_r && idx == `SDB_CMD_SELECT &&
		card_r == SDB_STBY) |=> card_r == SDB_TRAN)
		else $error("select did not enter transfer");

	spi_cov: cover property (@(posedge sd_clk_i) disable iff (!lrst_n)
		$rose(spi_r));
	ready_cov: cover property (@(posedge sd_clk_i) disable iff (!lrst_n)
		card_r == SDB_IDLE ##1 card_r == SDB_READY);
	tran_cov: cover property (@(posedge sd_clk_i) disable iff (!lrst_n)
		card_r == SDB_TRAN);
	wide_cov: cover property (@(posedge sd_clk_i) disable iff (!lrst_n)
		$rose(wide_r));
endmodule

// File: sdb_host.sv
// ----------------------------------------
// Host side model: card clock, CMD, DAT3
// ----------------------------------------
module sdb_host (
	output logic sd_clk_o,
	output logic cmd_o,
	output logic cmd_oe_o,
	output logic dat3_o,
	input wire logic card_oe_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// Set before any process starts, so a time-zero clocks call wins
	logic run = 1'b0;
	initial begin
		sd_clk_o = 1'b0;
		cmd_o = 1'b1;
		cmd_oe_o = 1'b0;
		dat3_o = 1'b1;
	end
	// Clock stands still between frames
	// real hosts stay at or below 50 MHz; card logic is cycle based
	always #6 if (run) sd_clk_o = ~sd_clk_o;

	function automatic logic [6:0] crc7(input logic [39:0] d);
		logic [6:0] c;
		logic fb;
		c = 7'h00;
		for (int i = 39; i >= 0; i--) begin
			fb = d[i] ^ c[6];
			c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
		end
		return c;
	endfunction

	task automatic clocks(input int n);
		run = 1'b1;
		repeat (n) @(negedge sd_clk_o);
		run = 1'b0;
	endtask

	// DAT3 level at CMD0, framed token
	task automatic send(input logic [5:0] idx, input logic [31:0] arg,
		input logic bad, input logic cs);
		logic [47:0] t;
		int w;
		t = {2'b01, idx, arg, crc7({2'b01, idx, arg}) ^ {6'h00, bad}, 1'b1};
		dat3_o = cs;
		run = 1'b1;
		@(negedge sd_clk_o);
		cmd_oe_o = 1'b1;
		for (int i = 47; i >= 0; i--) begin
			cmd_o = t[i];
			@(negedge sd_clk_o);
		end
		cmd_oe_o = 1'b0;
		cmd_o = 1'b1;
		for (w = 0; w < 12 && !card_oe_i; w++) @(negedge sd_clk_o);
		for (w = 0; w < 140 && card_oe_i; w++) @(negedge sd_clk_o);
		repeat (3) @(negedge sd_clk_o);
		run = 1'b0;
		dat3_o = 1'b1;
	endtask
endmodule

// File: sdb_card_tb.sv
module sdb_card_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// Card data: arbitrary values
	localparam logic [127:0] CID_V = 128'h5A1B2C3D4E5F60718293A4B5C6D7E801;
	localparam logic [127:0] CSD_V = 128'h400E0032000000000000000000000001;
	typedef struct {
		int len;
		logic [39:0] hdr;
		logic [39:0] msk;
	} sdb_note_s;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic init_done_i = 1'b0;
	logic dat_drv_en_i = 1'b0;
	logic [3:0] dat_drv_i = 4'h0;
	logic [3:0] drv;
	wire sd_clk, h_cmd, h_oe, dat3, cmd_o, cmd_oe, pu, spi, wide, sreq;
	wire [3:0] dat_o;
	wire [3:0] dat_oe;
	// Released CMD line floats high through its pull-up
	wire cmd_line = h_oe ? h_cmd : (cmd_oe ? cmd_o : 1'b1);
	int errors = 0;
	int checks_done = 0;
	int seed = 56;
	int resp_cnt = 0;
	int sreq_cnt = 0;
	int n = 0;
	int base;
	int spi_n = 0;
	logic [7:0] spi_b;
	logic [135:0] sh;
	logic [39:0] last_head;
	logic [15:0] rca;
	sdb_note_s notes[$];
	sdb_note_s nt;
	always #2.5 ref_clk_i = ~ref_clk_i;

	sdb_host sdb_host_i (.sd_clk_o(sd_clk), .cmd_o(h_cmd), .cmd_oe_o(h_oe),
		.dat3_o(dat3), .card_oe_i(cmd_oe));
	sdb_card #(.CID(CID_V), .CSD(CSD_V)) sdb_card_i (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .sd_clk_i(sd_clk), .cmd_i(cmd_line),
		.cmd_o(cmd_o), .cmd_oe_o(cmd_oe), .dat3_i(dat3), .dat_o(dat_o),
		.dat_oe_o(dat_oe), .dat3_pu_en_o(pu), .dat_drv_i(dat_drv_i),
		.dat_drv_en_i(dat_drv_en_i), .init_done_i(init_done_i),
		.spi_mode_o(spi), .bus_wide_o(wide), .status_req_o(sreq));

	task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict;
		$display("Checks %0d, errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Response monitor
	// ----------------------------------------
	task automatic take_note(input int len, input logic [39:0] head);
		resp_cnt++;
		if (notes.size() == 0) begin
			check("unexpected response", 1, 0);
		end else begin
			nt = notes.pop_front();
			check("response length", len, nt.len);
			check("response head", head & nt.msk, nt.hdr);
		end
	endtask

	always @(negedge sd_clk) begin
		if (cmd_oe === 1'b1) begin
			sh = {sh[134:0], cmd_o};
			n++;
		end else if (n > 0) begin
			base = n - 1;
			last_head = sh[base -: 40];
			take_note(n, last_head);
			n = 0;
		end
	end
	// SPI answer byte on DAT0, framed by its leading zero
	always @(negedge sd_clk) begin
		if (spi === 1'b1 && dat_oe[0] === 1'b1 &&
			(spi_n > 0 || dat_o[0] === 1'b0)) begin
			spi_b = {spi_b[6:0], dat_o[0]};
			spi_n++;
		end
		if (spi_n == 8) begin
			take_note(8, {32'h0, spi_b});
			spi_n = 0;
		end
	end
	always @(posedge ref_clk_i) if (sreq === 1'b1) sreq_cnt++;

	task automatic cmd(input logic [5:0] idx, input logic [31:0] arg,
		input int len, input logic [39:0] hdr, input logic [39:0] msk);
		if (len > 0) notes.push_back('{len, hdr, msk});
		sdb_host_i.send(idx, arg, 1'b0, 1'b1);
	endtask

	task automatic r1(input logic [5:0] idx, input logic [31:0] arg);
		cmd(idx, arg, 48, {2'b00, idx, 32'h0}, 40'hFF00000000);
	endtask

	task automatic drive_data(input int k, input logic [3:0] m);
		for (int i = 0; i < k; i++) begin
			@(posedge ref_clk_i);
			drv = 4'($random(seed));
			dat_drv_i <= drv;
			dat_drv_en_i <= 1'b1;
			sdb_host_i.clocks(2);
			check("data lines", {dat_oe, dat_o & m}, {m, drv & m});
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		fork
			sdb_host_i.clocks(80);
			begin
				repeat (10) @(posedge ref_clk_i);
				rst_n_i <= 1'b1;
			end
		join
		check("pull-up at power up", pu, 1);
		check("data enables at power up", dat_oe, 0);
		check("mode and width", {spi, wide}, 0);
		cmd(6'h00, 0, 0, 0, 0);
		check("mode after CMD0 high", spi, 0);
		sdb_host_i.send(6'h37, 0, 1'b1, 1'b1);
		check("bad token answered", resp_cnt, 0);
		r1(6'h37, 0);
		cmd(6'h29, 0, 48, 40'h3F00FF8000, '1);
		for (int k = 0; k < 2; k++) begin
			r1(6'h37, 0);
			cmd(6'h29, 32'h00FF8000, 48, {8'h3F, k[0], 31'h00FF8000}, '1);
			@(posedge ref_clk_i);
			init_done_i <= 1'b1;
		end
		cmd(6'h02, 0, 136, {8'h3F, CID_V[127:96]}, '1);
		cmd(6'h03, 0, 48, 40'h0300000000, 40'hFF00000000);
		rca = last_head[31:16];
		check("address is zero", rca == 16'h0, 0);
		r1(6'h07, {rca, 16'h0});
		r1(6'h37, {rca, 16'h0});
		r1(6'h0D, 0);
		repeat (6) @(posedge ref_clk_i);
		check("status requests", sreq_cnt, 1);
		drive_data(2, 4'h1);
		check("narrow enables", dat_oe, 4'h1);
		r1(6'h37, {rca, 16'h0});
		r1(6'h2A, 0);
		check("pull-up after ACMD42", pu, 0);
		cmd(6'h09, {rca, 16'h0}, 0, 0, 0);
		check("CMD9 in transfer", resp_cnt, 13);
		r1(6'h07, {rca, 16'h0});
		cmd(6'h09, {rca, 16'h0}, 136, {8'h3F, CSD_V[127:96]}, '1);
		cmd(6'h0A, {rca, 16'h0}, 136, {8'h3F, CID_V[127:96]}, '1);
		r1(6'h07, {rca, 16'h0});
		r1(6'h37, {rca, 16'h0});
		r1(6'h06, 32'h2);
		repeat (6) @(posedge ref_clk_i);
		check("wide bus", wide, 1);
		drive_data(4, 4'hF);
		check("wide enables", dat_oe, 4'hF);
		// Data engine idle, so DAT0 only carries SPI answers from here
		@(posedge ref_clk_i);
		dat_drv_en_i <= 1'b0;
		sdb_host_i.send(6'h00, 0, 1'b0, 1'b0);
		repeat (6) @(posedge ref_clk_i);
		check("mode after CMD0 low", spi, 1);
		notes.push_back('{8, 40'h01, 40'hFF});
		sdb_host_i.send(6'h37, 0, 1'b0, 1'b0);
		check("SPI answers", resp_cnt, 20);
		cmd(6'h00, 0, 0, 0, 0);
		repeat (6) @(posedge ref_clk_i);
		check("mode kept", spi, 1);
		check("reserved lines in SPI", dat_oe[3:1], 0);
		check("CMD line quiet in SPI", cmd_oe, 0);
		check("answers missing", notes.size(), 0);
		give_verdict();
	end

	initial begin
		#400us;
		errors++;
		give_verdict();
	end
endmodule
